// ---- hdl/pcs_config_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_config_select #(
	parameter int unsigned NVM_WORDS = 16,
	parameter int unsigned NVM_AW = 4
) (
	input wire logic core_clk, // System clock, 20 MHz.
	input wire logic rstn, // Power-on reset, asynchronous, active low.
	input wire logic scl_i, // Bus clock level.
	input wire logic sda_i, // Bus data level.
	output logic sda_o, // Bus data drive value, always low.
	output logic sda_oe, // High while pulling bus data low.
	input wire pcs_pkg::pcs_settings_t pin_cfg, // Values decoded from the pins.
	input wire pcs_pkg::pcs_settings_t nvm_cfg, // Stored default or user values.
	input wire logic [15:0] nvm_mask, // Stored source-selection mask.
	input wire logic restore_req, // Pulse: restore from stored values.
	input wire logic nvm_op_done, // Pulse: a store or restore finished.
	output logic [NVM_AW-1:0] nvm_rd_addr, // Stored word index for the checksum.
	input wire logic [15:0] nvm_rd_data, // Stored word at nvm_rd_addr.
	output pcs_pkg::pcs_settings_t active_cfg, // Settings in force.
	output logic [15:0] src_mask, // Source-selection mask in force.
	output logic cfg_loaded, // Pulse: settings groups were reloaded.
	output logic invalid_data, // Pulse: an unsupported write was seen.
	output logic crc_busy // High while the checksum is recomputed.
);

	pcs_pkg::pcs_state_t s_ff, nxt_s;
	logic [15:0] crc_val;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// Each group takes the pin value when its bit is one, else the stored one.
	function automatic pcs_pkg::pcs_settings_t pick_source(
		input logic [15:0] m,
		input pcs_pkg::pcs_settings_t pin,
		input pcs_pkg::pcs_settings_t nvm
	);
		pcs_pkg::pcs_settings_t r;
		r = nvm;
		if (m[pcs_pkg::MASK_STACK_BIT]) begin
			r.stack_setting = pin.stack_setting;
		end
		if (m[pcs_pkg::MASK_SYNC_BIT]) begin
			r.clk_sync_setting = pin.clk_sync_setting;
		end
		if (m[pcs_pkg::MASK_COMP_BIT]) begin
			r.loop_comp_setting = pin.loop_comp_setting;
		end
		if (m[pcs_pkg::MASK_ADDR_BIT]) begin
			r.target_addr = pin.target_addr;
		end
		if (m[pcs_pkg::MASK_PHASE_BIT]) begin
			r.phase_offset_order = pin.phase_offset_order;
		end
		if (m[pcs_pkg::MASK_RISE_BIT]) begin
			r.rise_time = pin.rise_time;
		end
		if (m[pcs_pkg::MASK_OC_BIT]) begin
			r.oc_fault_limit = pin.oc_fault_limit;
			r.oc_warn_limit = pin.oc_warn_limit;
		end
		if (m[pcs_pkg::MASK_RATE_BIT]) begin
			r.switching_rate = pin.switching_rate;
		end
		if (m[pcs_pkg::MASK_OUTV_BIT]) begin
			r.out_volt_cmd = pin.out_volt_cmd;
			r.out_volt_scale = pin.out_volt_scale;
			r.out_volt_max = pin.out_volt_max;
			r.out_volt_min = pin.out_volt_min;
		end
		return r;
	endfunction

	function automatic logic is_reserved_addr(input logic [6:0] a);
		return (a == pcs_pkg::RSV_ADDR_A) || (a == pcs_pkg::RSV_ADDR_B) ||
			(a == pcs_pkg::RSV_ADDR_C) || (a == pcs_pkg::RSV_ADDR_D);
	endfunction

	function automatic logic is_known_cmd(input logic [7:0] c);
		return (c == pcs_pkg::CMD_SRC_MASK) || (c == pcs_pkg::CMD_TGT_ADDR) ||
			(c == pcs_pkg::CMD_CRC);
	endfunction

	// Number of data bytes a legal write of the command carries.
	function automatic logic [2:0] wr_bytes(input logic [7:0] c);
		logic [2:0] r;
		r = pcs_pkg::WR_BYTES_CRC;
		if (c == pcs_pkg::CMD_SRC_MASK) begin
			r = pcs_pkg::WR_BYTES_MASK;
		end else if (c == pcs_pkg::CMD_TGT_ADDR) begin
			r = pcs_pkg::WR_BYTES_ADDR;
		end
		return r;
	endfunction

	// Byte returned at position idx of a read; words go low byte first.
	function automatic logic [7:0] rd_byte(
		input logic [7:0] c,
		input logic [1:0] idx,
		input logic [15:0] m,
		input logic [6:0] a,
		input logic [15:0] crc
	);
		logic [7:0] r;
		r = pcs_pkg::RD_FILL;
		case (c)
			pcs_pkg::CMD_SRC_MASK: begin
				if (idx == 2'h0) begin
					r = m[7:0];
				end else if (idx == 2'h1) begin
					r = m[15:8];
				end
			end
			pcs_pkg::CMD_TGT_ADDR: begin
				if (idx == 2'h0) begin
					r = {1'b0, a};
				end
			end
			pcs_pkg::CMD_CRC: begin
				if (idx == 2'h0) begin
					r = crc[7:0];
				end else if (idx == 2'h1) begin
					r = crc[15:8];
				end
			end
			default: begin
				r = pcs_pkg::RD_FILL;
			end
		endcase
		return r;
	endfunction

	// Inputs are synchronous to core_clk, so one registered copy gives the edges.
	assign scl_rise = scl_i & ~s_ff.scl_d;
	assign scl_fall = ~scl_i & s_ff.scl_d;
	assign bus_start = scl_i & s_ff.scl_d & s_ff.sda_d & ~sda_i;
	assign bus_stop = scl_i & s_ff.scl_d & ~s_ff.sda_d & sda_i;

	always_comb begin
		logic [7:0] tb;
		tb = 8'h00;
		nxt_s = s_ff;
		nxt_s.scl_d = scl_i;
		nxt_s.sda_d = sda_i;
		nxt_s.inv = 1'b0;
		nxt_s.loaded = 1'b0;
		nxt_s.crc_go = 1'b0;

		// The mask is settled one cycle ahead of the groups it steers.
		unique case (s_ff.ld)
			pcs_pkg::LD_POR: begin
				nxt_s.pins = pin_cfg;
				nxt_s.mask = nvm_mask;
				nxt_s.crc_go = 1'b1;
				nxt_s.ld = pcs_pkg::LD_APPLY;
			end
			pcs_pkg::LD_MASK: begin
				nxt_s.mask = nvm_mask;
				nxt_s.ld = pcs_pkg::LD_APPLY;
			end
			pcs_pkg::LD_APPLY: begin
				nxt_s.act = pick_source(s_ff.mask, s_ff.pins, nvm_cfg);
				nxt_s.loaded = 1'b1;
				nxt_s.ld = pcs_pkg::LD_RUN;
			end
			pcs_pkg::LD_RUN: begin
				if (restore_req) begin
					nxt_s.ld = pcs_pkg::LD_MASK;
				end
			end
		endcase
		if (nvm_op_done) begin
			nxt_s.crc_go = 1'b1;
		end

		if (bus_start || bus_stop) begin
			// A write takes effect at its end, and only with the exact byte count.
			if (s_ff.rxcnt >= 3'h2 && is_known_cmd(s_ff.cmd)) begin
				if (s_ff.rxcnt != wr_bytes(s_ff.cmd) + 3'h1) begin
					nxt_s.inv = 1'b1;
				end else if (s_ff.cmd == pcs_pkg::CMD_SRC_MASK) begin
					nxt_s.mask = s_ff.wdata;
				end else if (s_ff.cmd == pcs_pkg::CMD_TGT_ADDR) begin
					if (is_reserved_addr(s_ff.wdata[6:0])) begin
						nxt_s.inv = 1'b1;
					end else begin
						nxt_s.act.target_addr = s_ff.wdata[6:0];
					end
				end
			end
			nxt_s.rxcnt = 3'h0;
			nxt_s.bitcnt = 4'h0;
			nxt_s.sda_oe = 1'b0;
			nxt_s.bus = bus_start ? pcs_bus_addr() : pcs_pkg::BUS_IDLE;
		end else begin
			unique case (s_ff.bus)
				pcs_pkg::BUS_IDLE: begin
					nxt_s.sda_oe = 1'b0;
				end
				pcs_pkg::BUS_ADDR, pcs_pkg::BUS_RX: begin
					if (scl_rise) begin
						nxt_s.shreg = {s_ff.shreg[6:0], sda_i};
						nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
					end else if (scl_fall && s_ff.bitcnt == 4'h8) begin
						nxt_s.bitcnt = 4'h0;
						if (s_ff.bus == pcs_pkg::BUS_ADDR) begin
							if (s_ff.shreg[7:1] == s_ff.act.target_addr) begin
								nxt_s.rd_mode = s_ff.shreg[0];
								nxt_s.txidx = 2'h0;
								nxt_s.sda_oe = 1'b1;
								nxt_s.bus = pcs_pkg::BUS_ACK;
							end else begin
								nxt_s.bus = pcs_pkg::BUS_IDLE;
							end
						end else begin
							if (s_ff.rxcnt == 3'h0) begin
								nxt_s.cmd = s_ff.shreg;
							end else if (s_ff.rxcnt == 3'h1) begin
								nxt_s.wdata[7:0] = s_ff.shreg;
							end else if (s_ff.rxcnt == 3'h2) begin
								nxt_s.wdata[15:8] = s_ff.shreg;
							end
							if (s_ff.rxcnt != 3'h7) begin
								nxt_s.rxcnt = s_ff.rxcnt + 3'h1;
							end
							nxt_s.sda_oe = 1'b1;
							nxt_s.bus = pcs_pkg::BUS_ACK;
						end
					end
				end
				pcs_pkg::BUS_ACK, pcs_pkg::BUS_TXACK: begin
					if (s_ff.bus == pcs_pkg::BUS_TXACK && scl_rise && sda_i) begin
						nxt_s.bus = pcs_pkg::BUS_IDLE;
					end else if (scl_fall) begin
						nxt_s.sda_oe = 1'b0;
						if (s_ff.rd_mode) begin
							tb = rd_byte(s_ff.cmd, s_ff.txidx, s_ff.mask,
								s_ff.act.target_addr, crc_val);
							nxt_s.txbyte = tb;
							nxt_s.sda_oe = ~tb[7];
							if (s_ff.txidx != 2'h2) begin
								nxt_s.txidx = s_ff.txidx + 2'h1;
							end
							nxt_s.bus = pcs_pkg::BUS_TX;
						end else begin
							nxt_s.bus = pcs_pkg::BUS_RX;
						end
					end
				end
				pcs_pkg::BUS_TX: begin
					if (scl_rise) begin
						nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (s_ff.bitcnt == 4'h8) begin
							nxt_s.bitcnt = 4'h0;
							nxt_s.sda_oe = 1'b0;
							nxt_s.bus = pcs_pkg::BUS_TXACK;
						end else begin
							nxt_s.txbyte = {s_ff.txbyte[6:0], 1'b0};
							nxt_s.sda_oe = ~s_ff.txbyte[6];
						end
					end
				end
				default: begin
					nxt_s.sda_oe = 1'b0;
					nxt_s.bus = pcs_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	function automatic pcs_pkg::pcs_bus_t pcs_bus_addr();
		return pcs_pkg::BUS_ADDR;
	endfunction

	// Reset puts the loader at the power-on step so the pins are caught after release.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '{
				ld: pcs_pkg::LD_POR,
				bus: pcs_pkg::BUS_IDLE,
				scl_d: 1'b1,
				sda_d: 1'b1,
				bitcnt: 4'h0,
				shreg: 8'h00,
				txbyte: 8'h00,
				rd_mode: 1'b0,
				cmd: 8'h00,
				rxcnt: 3'h0,
				txidx: 2'h0,
				wdata: 16'h0000,
				sda_oe: 1'b0,
				mask: pcs_pkg::MASK_RST,
				pins: pcs_pkg::SETTINGS_RST,
				act: pcs_pkg::SETTINGS_RST,
				inv: 1'b0,
				loaded: 1'b0,
				crc_go: 1'b0
			};
		end else begin
			s_ff <= nxt_s;
		end
	end

	pcs_crc16 #(
		.WORDS(NVM_WORDS),
		.AW(NVM_AW)
	) u_crc (
		.core_clk(core_clk),
		.rstn(rstn),
		.start(s_ff.crc_go),
		.rd_addr(nvm_rd_addr),
		.rd_data(nvm_rd_data),
		.crc(crc_val),
		.busy(crc_busy)
	);

	// Open drain: the pin is only ever pulled low.
	assign sda_o = 1'b0;
	assign sda_oe = s_ff.sda_oe;
	assign active_cfg = s_ff.act;
	assign src_mask = s_ff.mask;
	assign cfg_loaded = s_ff.loaded;
	assign invalid_data = s_ff.inv;

endmodule // pcs_config_select
`default_nettype wire

// ---- hdl/pcs_pkg.sv ----
`default_nettype none
package pcs_pkg;

	// Command codes served by this block.
	localparam logic [7:0] CMD_SRC_MASK = 8'hEE;
	localparam logic [7:0] CMD_TGT_ADDR = 8'hEF;
	localparam logic [7:0] CMD_CRC = 8'hF0;

	// Data bytes carried by a write of each command.
	localparam logic [2:0] WR_BYTES_MASK = 3'h2;
	localparam logic [2:0] WR_BYTES_ADDR = 3'h1;
	localparam logic [2:0] WR_BYTES_CRC = 3'h0;

	// Reserved target addresses that a bus write never sets; loads from pins or stored values do not check them.
	localparam logic [6:0] RSV_ADDR_A = 7'h0C;
	localparam logic [6:0] RSV_ADDR_B = 7'h28;
	localparam logic [6:0] RSV_ADDR_C = 7'h37;
	localparam logic [6:0] RSV_ADDR_D = 7'h61;

	// Bit positions of the source-selection mask.
	localparam int MASK_STACK_BIT = 12;
	localparam int MASK_SYNC_BIT = 11;
	localparam int MASK_COMP_BIT = 9;
	localparam int MASK_ADDR_BIT = 8;
	localparam int MASK_PHASE_BIT = 5;
	localparam int MASK_RISE_BIT = 3;
	localparam int MASK_OC_BIT = 2;
	localparam int MASK_RATE_BIT = 1;
	localparam int MASK_OUTV_BIT = 0;

	// Reset values before the first load completes, and the fill byte for reads.
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [7:0] RD_FILL = 8'hFF;

	// Checksum engine.
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'h0000;

	typedef struct packed {
		logic [15:0] out_volt_cmd;
		logic [15:0] out_volt_scale;
		logic [15:0] out_volt_max;
		logic [15:0] out_volt_min;
		logic [15:0] switching_rate;
		logic [15:0] oc_fault_limit;
		logic [15:0] oc_warn_limit;
		logic [15:0] rise_time;
		logic [15:0] phase_offset_order;
		logic [15:0] loop_comp_setting;
		logic [7:0] clk_sync_setting;
		logic [3:0] stack_setting;
		logic [6:0] target_addr;
	} pcs_settings_t;

	localparam pcs_settings_t SETTINGS_RST = '0;

	typedef enum logic [1:0] {
		LD_POR = 2'h0,
		LD_APPLY = 2'h1,
		LD_RUN = 2'h3,
		LD_MASK = 2'h2
	} pcs_ld_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'h0,
		BUS_ADDR = 3'h1,
		BUS_ACK = 3'h3,
		BUS_RX = 3'h2,
		BUS_TX = 3'h6,
		BUS_TXACK = 3'h7
	} pcs_bus_t;

	typedef struct packed {
		pcs_ld_t ld;
		pcs_bus_t bus;
		logic scl_d;
		logic sda_d;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] txbyte;
		logic rd_mode;
		logic [7:0] cmd;
		logic [2:0] rxcnt;
		logic [1:0] txidx;
		logic [15:0] wdata;
		logic sda_oe;
		logic [15:0] mask;
		pcs_settings_t pins;
		pcs_settings_t act;
		logic inv;
		logic loaded;
		logic crc_go;
	} pcs_state_t;

endpackage
`default_nettype wire

// ---- hdl/pcs_crc16.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_crc16 #(
	parameter int unsigned WORDS = 16,
	parameter int unsigned AW = 4
) (
	input wire logic core_clk, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic start, // Pulse: restart the checksum pass.
	output logic [AW-1:0] rd_addr, // Word index into the stored settings.
	input wire logic [15:0] rd_data, // Stored word at rd_addr, same cycle.
	output logic [15:0] crc, // Last completed checksum.
	output logic busy // High while a pass runs.
);

	typedef struct packed {
		logic busy;
		logic [AW-1:0] addr;
		logic [15:0] acc;
		logic [15:0] crc;
	} crc_state_t;

	crc_state_t s_ff, nxt_s;

	function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [15:0] d);
		logic [15:0] c;
		logic fb;
		c = c_in;
		for (int i = 15; i >= 0; i--) begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0};
			if (fb) begin
				c = c ^ pcs_pkg::CRC_POLY;
			end
		end
		return c;
	endfunction

	always_comb begin
		nxt_s = s_ff;
		if (start) begin
			nxt_s.busy = 1'b1;
			nxt_s.addr = '0;
			nxt_s.acc = pcs_pkg::CRC_INIT;
		end else if (s_ff.busy) begin
			nxt_s.acc = crc_step(s_ff.acc, rd_data);
			if (s_ff.addr == AW'(WORDS - 1)) begin
				nxt_s.busy = 1'b0;
				nxt_s.crc = crc_step(s_ff.acc, rd_data);
			end else begin
				nxt_s.addr = s_ff.addr + AW'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rd_addr = s_ff.addr;
	assign crc = s_ff.crc;
	assign busy = s_ff.busy;

endmodule // pcs_crc16
`default_nettype wire

// ---- tb/pcs_config_select_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_config_select_monitor #(
	parameter int unsigned NVM_WORDS = 16,
	parameter int unsigned NVM_AW = 4
) (
	input wire logic core_clk, // Clock.
	input wire logic rstn, // Reset, active low.
	input wire logic scl_i, // Bus clock.
	input wire logic sda_o, // Data drive value.
	input wire logic sda_oe, // Data drive enable.
	input wire pcs_pkg::pcs_settings_t pin_cfg, // Pin values.
	input wire pcs_pkg::pcs_settings_t nvm_cfg, // Stored values.
	input wire logic nvm_op_done, // Store or restore finished.
	input wire logic restore_req, // Restore request.
	input wire logic [NVM_AW-1:0] nvm_rd_addr, // Checksum word index.
	input wire pcs_pkg::pcs_settings_t active_cfg, // Settings in force.
	input wire logic [15:0] src_mask, // Mask in force.
	input wire logic cfg_loaded, // Reload pulse.
	input wire logic invalid_data, // Invalid write pulse.
	input wire logic crc_busy // Checksum pass running.
);
	pcs_pkg::pcs_settings_t pins_ff;
	pcs_pkg::pcs_settings_t want;
	logic seen_ff;
	logic booted_ff;

	// Pins are held as seen at the first edge, so a later pin change exposes any resampling.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			seen_ff <= 1'b0;
			booted_ff <= 1'b0;
			pins_ff <= pcs_pkg::SETTINGS_RST;
		end else begin
			seen_ff <= 1'b1;
			if (!seen_ff) pins_ff <= pin_cfg;
			if (cfg_loaded) booted_ff <= 1'b1;
		end
	end

	always_comb begin
		want = nvm_cfg;
		if (src_mask[0]) begin
			want.out_volt_cmd = pins_ff.out_volt_cmd;
			want.out_volt_scale = pins_ff.out_volt_scale;
			want.out_volt_max = pins_ff.out_volt_max;
			want.out_volt_min = pins_ff.out_volt_min;
		end
		if (src_mask[1]) want.switching_rate = pins_ff.switching_rate;
		if (src_mask[2]) begin
			want.oc_fault_limit = pins_ff.oc_fault_limit;
			want.oc_warn_limit = pins_ff.oc_warn_limit;
		end
		if (src_mask[3]) want.rise_time = pins_ff.rise_time;
		if (src_mask[5]) want.phase_offset_order = pins_ff.phase_offset_order;
		if (src_mask[8]) want.target_addr = pins_ff.target_addr;
		if (src_mask[9]) want.loop_comp_setting = pins_ff.loop_comp_setting;
		if (src_mask[11]) want.clk_sync_setting = pins_ff.clk_sync_setting;
		if (src_mask[12]) want.stack_setting = pins_ff.stack_setting;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_pass_done;
		##[1:40] !crc_busy;
	endsequence
	property p_group_pick;
		cfg_loaded |-> active_cfg == want;
	endproperty
	property p_no_reload;
		booted_ff && $changed(src_mask) && !$past(restore_req, 2) |-> !cfg_loaded [*3];
	endproperty
	property p_crc_restart;
		nvm_op_done |-> ##2 crc_busy;
	endproperty
	property p_crc_ends;
		$rose(crc_busy) |-> s_pass_done;
	endproperty
	property p_crc_walk;
		crc_busy && $past(crc_busy) && !$past(nvm_op_done, 2)
			|-> nvm_rd_addr == NVM_AW'($past(nvm_rd_addr) + 1'b1);
	endproperty
	property p_sda_change;
		$changed(sda_oe) |-> !scl_i && !sda_o;
	endproperty
	property p_loaded_pulse;
		cfg_loaded |=> !cfg_loaded;
	endproperty
	property p_rsv_never;
		!(active_cfg.target_addr inside {7'h0C, 7'h28, 7'h37, 7'h61});
	endproperty
	property p_inv_keeps;
		invalid_data |-> $stable(active_cfg.target_addr) && $stable(src_mask);
	endproperty

	a_group_pick: assert property (p_group_pick)
		else $error("settings group source mismatch");
	a_no_reload: assert property (p_no_reload)
		else $error("mask write caused a reload");
	a_crc_restart: assert property (p_crc_restart)
		else $error("checksum pass not restarted");
	a_crc_ends: assert property (p_crc_ends)
		else $error("checksum pass too long");
	a_crc_walk: assert property (p_crc_walk)
		else $error("checksum word index skipped");
	a_sda_change: assert property (p_sda_change)
		else $error("data drive changed while clock high");
	a_loaded_pulse: assert property (p_loaded_pulse)
		else $error("reload pulse longer than one cycle");
	a_rsv_never: assert property (p_rsv_never)
		else $error("reserved address taken");
	a_inv_keeps: assert property (p_inv_keeps)
		else $error("invalid write was applied");
endmodule // pcs_config_select_monitor

bind pcs_config_select pcs_config_select_monitor #(.NVM_WORDS(NVM_WORDS), .NVM_AW(NVM_AW)) u_mon (
	.core_clk, .rstn, .scl_i, .sda_o, .sda_oe, .pin_cfg, .nvm_cfg, .nvm_op_done, .restore_req,
	.nvm_rd_addr, .active_cfg, .src_mask, .cfg_loaded, .invalid_data, .crc_busy);
`default_nettype wire

// ---- tb/pcs_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_host (
	input wire logic core_clk, // Bus timing counts these cycles.
	input wire logic sda, // Data wire, pulled up.
	output var logic scl, // Bus clock, high between frames.
	output var logic sda_low // High while pulling data low.
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic half();
		repeat (4) @(negedge core_clk);
	endtask

	// Also serves as repeated start, since it first releases data with the clock low.
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
	endtask

	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask

	task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] r);
		logic [8:0] v;
		v = {d, last};
		for (int i = 8; i >= 0; i--) begin
			sda_low = !v[i];
			half();
			scl = 1'b1;
			half();
			v[i] = sda;
			scl = 1'b0;
		end
		r = v[8:1];
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input int n);
		logic [7:0] r;
		start();
		byte_io({a, 1'b0}, 1'b1, r);
		byte_io(c, 1'b1, r);
		for (int i = 0; i < n; i++) byte_io(d[8*i+:8], 1'b1, r);
		stop();
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n, output logic [15:0] d);
		logic [7:0] r;
		d = 16'hFFFF;
		start();
		byte_io({a, 1'b0}, 1'b1, r);
		byte_io(c, 1'b1, r);
		start();
		byte_io({a, 1'b1}, 1'b1, r);
		for (int i = 0; i < n; i++) begin
			byte_io(8'hFF, i == n - 1, r);
			d[8*i+:8] = r;
		end
		stop();
	endtask
endmodule // pcs_host
`default_nettype wire

// ---- tb/tb_pcs_config_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pcs_config_select;
	localparam logic [6:0] BOOT_ADDR = 7'h24;
	localparam logic [6:0] PIN_ADDR = 7'h22;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic scl;
	logic sda;
	logic sda_low;
	logic sda_o;
	logic sda_oe;
	pcs_pkg::pcs_settings_t pin_cfg;
	pcs_pkg::pcs_settings_t nvm_cfg;
	pcs_pkg::pcs_settings_t active_cfg;
	logic [15:0] nvm_mask = 16'h0000;
	logic restore_req = 1'b0;
	logic nvm_op_done = 1'b0;
	logic [1:0] nvm_rd_addr;
	logic [15:0] nvm_rd_data;
	logic [15:0] src_mask;
	logic cfg_loaded;
	logic invalid_data;
	logic crc_busy;
	logic [15:0] w [4] = '{16'hC0DE, 16'h0F0F, 16'h8001, 16'h1357};
	logic [15:0] masks [11] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0020, 16'h0100,
		16'h0200, 16'h0800, 16'h1000, 16'h1B2F, 16'h0000};
	logic [6:0] rsv [4] = '{7'h0C, 7'h28, 7'h37, 7'h61};
	logic [15:0] d;
	int n_fail = 0;
	int n_tests = 0;
	int n_inv = 0;

	always #25 core_clk = !core_clk;
	assign sda = (sda_oe ? sda_o : 1'b1) & !sda_low;
	assign nvm_rd_data = w[nvm_rd_addr];
	always @(negedge core_clk) if (invalid_data === 1'b1) n_inv++;

	pcs_config_select #(.NVM_WORDS(4), .NVM_AW(2)) DUT (.core_clk, .rstn, .scl_i(scl),
		.sda_i(sda), .sda_o, .sda_oe, .pin_cfg, .nvm_cfg, .nvm_mask, .restore_req, .nvm_op_done,
		.nvm_rd_addr, .nvm_rd_data, .active_cfg, .src_mask, .cfg_loaded, .invalid_data, .crc_busy);
	pcs_host host (.core_clk, .sda, .scl, .sda_low);

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wload();
		int i;
		for (i = 0; i < 60 && cfg_loaded !== 1'b1; i++) @(negedge core_clk);
		chk(16'(i < 60), 16'h0001);
	endtask

	task automatic wbusy();
		int i;
		for (i = 0; i < 60 && crc_busy !== 1'b0; i++) @(negedge core_clk);
		chk(16'(i < 60), 16'h0001);
	endtask

	function automatic logic [15:0] crc_of();
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 0; i < 4; i++)
			for (int b = 15; b >= 0; b--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i][b]) ? 16'h8005 : 16'h0000);
		return c;
	endfunction

	task automatic finish_test();
		$display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge core_clk);
		n_fail++;
		finish_test();
	end

	initial begin
		pin_cfg = '1;
		pin_cfg.target_addr = PIN_ADDR;
		nvm_cfg = '0;
		nvm_cfg.target_addr = BOOT_ADDR;
		repeat (12) @(negedge core_clk);
		rstn = 1'b1;
		wload();
		pin_cfg = '0;
		chk(src_mask, 16'h0000);
		wbusy();
		host.rd(BOOT_ADDR, pcs_pkg::CMD_CRC, 2, d);
		chk(d, crc_of());
		w[2] = 16'h5AA5;
		nvm_op_done = 1'b1;
		@(negedge core_clk);
		nvm_op_done = 1'b0;
		// The pass starts two edges after the pulse, so busy is not yet up here.
		@(negedge core_clk);
		wbusy();
		host.rd(BOOT_ADDR, pcs_pkg::CMD_CRC, 2, d);
		chk(d, crc_of());
		$display("checksum test done");
		// Each mask bit is restored alone, then all together, then none.
		foreach (masks[i]) begin
			nvm_mask = masks[i];
			restore_req = 1'b1;
			@(negedge core_clk);
			restore_req = 1'b0;
			wload();
			chk(src_mask, masks[i]);
			d = {9'h000, (masks[i][8] ? PIN_ADDR : BOOT_ADDR)};
			chk({9'h000, active_cfg.target_addr}, d);
		end
		$display("restore test done");
		host.wr(BOOT_ADDR, pcs_pkg::CMD_SRC_MASK, 16'h1305, 2);
		host.rd(BOOT_ADDR, pcs_pkg::CMD_SRC_MASK, 2, d);
		chk(d, 16'h1305);
		chk({9'h000, active_cfg.target_addr}, {9'h000, BOOT_ADDR});
		host.wr(BOOT_ADDR, pcs_pkg::CMD_TGT_ADDR, 16'h00BB, 1);
		host.rd(7'h3B, pcs_pkg::CMD_TGT_ADDR, 1, d);
		chk(d, 16'hFF3B);
		host.rd(BOOT_ADDR, pcs_pkg::CMD_TGT_ADDR, 1, d);
		chk(d, 16'hFFFF);
		foreach (rsv[i]) host.wr(7'h3B, pcs_pkg::CMD_TGT_ADDR, {9'h000, rsv[i]}, 1);
		host.wr(7'h3B, pcs_pkg::CMD_CRC, 16'h1234, 2);
		host.wr(7'h3B, pcs_pkg::CMD_SRC_MASK, 16'h0001, 1);
		// Data for a command this block does not serve is dropped without a flag.
		host.wr(7'h3B, 8'hED, 16'h0001, 1);
		host.rd(7'h3B, pcs_pkg::CMD_TGT_ADDR, 1, d);
		chk(d, 16'hFF3B);
		chk(16'(n_inv), 16'h0006);
		chk(src_mask, 16'h1305);
		$display("bus test done");
		finish_test();
	end
endmodule // tb_pcs_config_select
`default_nettype wire
